// ---- design/parity_report_pkg.sv ----
/*
  package of the data parity reporting block: register map, field positions,
  reset values and the transaction and bus-side carriers.
  assumes a single clock domain and a plain address/strobe register port.
*/
`default_nettype none
package parity_report_pkg;

  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam int EVENT_COUNT = 4;

  // register offsets
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;

  // control fields
  localparam int PRI_RESP_EN_BIT = 0;
  localparam int SEC_RESP_EN_BIT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h0;

  // parity status fields
  localparam int PRI_MDPD_BIT = 0;
  localparam int SEC_MDPD_BIT = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;

  // interrupt event fields
  localparam int EV_PRI_MDPD_BIT = 0;
  localparam int EV_SEC_MDPD_BIT = 1;
  localparam int EV_PRI_PERR_BIT = 2;
  localparam int EV_SEC_PERR_BIT = 3;
  localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  typedef enum logic [1:0] {
    KIND_READ,
    KIND_POSTED,
    KIND_DELAYED
  } txn_kind_type;

  // the transaction now crossing the bridge
  typedef struct packed {
    logic start;
    txn_kind_type kind;
    logic upstream;
  } txn_type;

  // bridge activity on one bus
  typedef struct packed {
    logic data_phase;
    logic bridge_master;
    logic bridge_target;
    logic parity_fault;
    logic completion;
  } bus_side_type;

endpackage : parity_report_pkg

`default_nettype wire

// ---- design/sticky_bits.sv ----
/*
  a row of sticky flags: hardware sets, the owner clears, set wins.
  assumes set and clear are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sticky_bits #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,               // system clock
  input wire logic rst_n,             // async reset, active low
  input wire logic [WIDTH-1:0] set,   // per-bit set pulse
  input wire logic [WIDTH-1:0] clear, // per-bit clear pulse
  output logic [WIDTH-1:0] flags      // held flags
);

  wire [WIDTH-1:0] next_flags = set | (flags & ~clear);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags <= RESET_VALUE;
    else
      flags <= next_flags;
  end

endmodule : sticky_bits

`default_nettype wire

// ---- design/parity_report.sv ----
/*
  data parity error reporting of a two-port bridge: master data parity
  detected status for both buses and the two parity error pin drivers.
  assumes transaction and bus-side descriptors and the sampled parity error
  pins are synchronous to clk; the pin wire is resolved outside from oe.
*/
// Contract
// - primary master parity bit needs bridge primary master, primary enable, error.
// - primary master parity bit only for upstream transactions, primary-bus errors.
// - secondary master parity bit needs bridge secondary master, secondary enable, error.
// - secondary master parity bit only for downstream transactions, secondary-bus errors.
// - primary pin driven only as write target or read initiator there.
// - primary pin assertion requires primary parity response enable.
// - primary pin for primary errors on upstream read, downstream posted/delayed write.
// - secondary pin error on downstream delayed completion forwards to primary pin.
// - forwarding only if the primary bus saw no error itself.
// - secondary pin driven only as write target or read initiator there.
// - secondary pin assertion requires secondary parity response enable.
// - secondary pin for secondary errors, and forwarded upstream delayed write errors.
`timescale 1ns/1ps
`default_nettype none

module parity_report (
  input wire logic clk,                                 // 10 MHz clock
  input wire logic rst_n,                               // async reset, active low
  input wire logic [7:0] reg_addr,                      // register byte address
  input wire logic [31:0] reg_wdata,                    // register write data
  input wire logic reg_wr,                              // write strobe
  input wire logic reg_rd,                              // read strobe
  output logic [31:0] reg_rdata,                        // read data, cycle after read
  output logic irq,                                     // level interrupt
  input wire parity_report_pkg::txn_type txn,           // crossing transaction
  input wire parity_report_pkg::bus_side_type pri_bus,  // primary bus activity
  input wire parity_report_pkg::bus_side_type sec_bus,  // secondary bus activity
  input wire logic primary_parity_err_n,                // primary pin level in
  output logic primary_parity_err_out,                  // primary pin drive value
  output logic primary_parity_err_oe,                   // primary pin enable
  input wire logic secondary_parity_err_n,              // secondary pin level in
  output logic secondary_parity_err_out,                // secondary pin drive value
  output logic secondary_parity_err_oe                  // secondary pin enable
);

  logic [1:0] control;
  logic [1:0] status;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic pri_fault_seen;
  logic sec_fault_seen;

  // register decode
  wire hit_control = reg_addr == parity_report_pkg::CONTROL_OFFSET;
  wire hit_status = reg_addr == parity_report_pkg::STATUS_OFFSET;
  wire hit_irq_status = reg_addr == parity_report_pkg::IRQ_STATUS_OFFSET;
  wire hit_irq_mask = reg_addr == parity_report_pkg::IRQ_MASK_OFFSET;
  wire wr_control = reg_wr & hit_control;
  wire wr_status = reg_wr & hit_status;
  wire wr_irq_mask = reg_wr & hit_irq_mask;
  wire rd_irq_status = reg_rd & hit_irq_status;

  wire pri_resp_en = control[parity_report_pkg::PRI_RESP_EN_BIT];
  wire sec_resp_en = control[parity_report_pkg::SEC_RESP_EN_BIT];

  // transaction classification
  wire is_read = txn.kind == parity_report_pkg::KIND_READ;
  wire is_posted = txn.kind == parity_report_pkg::KIND_POSTED;
  wire is_delayed = txn.kind == parity_report_pkg::KIND_DELAYED;
  wire is_write = is_posted | is_delayed;
  wire up = txn.upstream;

  // error sources per bus; the pins are active low
  wire pri_pin_seen = ~primary_parity_err_n & pri_bus.data_phase;
  wire sec_pin_seen = ~secondary_parity_err_n & sec_bus.data_phase;
  wire pri_err = pri_pin_seen | pri_bus.parity_fault;
  wire sec_err = sec_pin_seen | sec_bus.parity_fault;

  wire pri_mdpd_cond = pri_bus.bridge_master & pri_resp_en & pri_err;
  wire set_pri_mdpd = pri_mdpd_cond & up;
  wire sec_mdpd_cond = sec_bus.bridge_master & sec_resp_en & sec_err;
  wire set_sec_mdpd = sec_mdpd_cond & ~up;

  // write target or read initiator on primary
  wire drives_pri = (pri_bus.bridge_target & is_write) | (pri_bus.bridge_master & is_read);
  // write target or read initiator on secondary
  wire drives_sec = (sec_bus.bridge_target & is_write) | (sec_bus.bridge_master & is_read);

  wire pri_local_case = (up & is_read) | (~up & is_write);
  wire pri_local = pri_bus.parity_fault & drives_pri & pri_local_case;
  // forward secondary pin during downstream delayed write completion
  wire pri_fwd_case = sec_pin_seen & sec_bus.completion & ~up & is_delayed & sec_resp_en;
  // no forwarding when the primary side already saw the error
  wire pri_fwd = pri_fwd_case & ~pri_fault_seen & ~pri_bus.parity_fault;
  wire pri_assert = pri_resp_en & (pri_local | pri_fwd);

  wire sec_local_case = (~up & is_read) | (up & is_write);
  wire sec_local = sec_bus.parity_fault & drives_sec & sec_local_case;
  // forward primary pin during upstream delayed write completion
  wire sec_fwd_case = pri_pin_seen & pri_bus.completion & up & is_delayed & pri_resp_en;
  wire sec_fwd = sec_fwd_case & ~sec_fault_seen & ~sec_bus.parity_fault;
  wire sec_assert = sec_resp_en & (sec_local | sec_fwd);

  wire [1:0] status_set = {set_sec_mdpd, set_pri_mdpd};
  wire [1:0] status_clear = wr_status ? reg_wdata[1:0] : 2'h0;
  wire [3:0] irq_set = {sec_assert, pri_assert, set_sec_mdpd, set_pri_mdpd};
  wire [3:0] irq_clear = rd_irq_status ? 4'hF : 4'h0;
  wire next_irq = |(irq_status & irq_mask);

  // read data selection
  wire [31:0] next_rdata =
    !reg_rd ? 32'h0 :
    hit_control ? {30'h0, control} :
    hit_status ? {30'h0, status} :
    hit_irq_status ? {28'h0, irq_status} :
    hit_irq_mask ? {28'h0, irq_mask} : 32'h0;

  sticky_bits #(
    .WIDTH(2),
    .RESET_VALUE(parity_report_pkg::STATUS_RESET)
  ) status_bits (
    .clk(clk),
    .rst_n(rst_n),
    .set(status_set),
    .clear(status_clear),
    .flags(status)
  );

  sticky_bits #(
    .WIDTH(parity_report_pkg::EVENT_COUNT),
    .RESET_VALUE(parity_report_pkg::IRQ_STATUS_RESET)
  ) irq_bits (
    .clk(clk),
    .rst_n(rst_n),
    .set(irq_set),
    .clear(irq_clear),
    .flags(irq_status)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control <= parity_report_pkg::CONTROL_RESET;
      irq_mask <= parity_report_pkg::IRQ_MASK_RESET;
    end
    else
    begin
      if (wr_control)
        control <= reg_wdata[1:0];
      if (wr_irq_mask)
        irq_mask <= reg_wdata[3:0];
    end
  end

  // per-transaction memory of own primary/secondary detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pri_fault_seen <= 1'b0;
      sec_fault_seen <= 1'b0;
    end
    else
    begin
      pri_fault_seen <= (pri_fault_seen & ~txn.start) | pri_bus.parity_fault;
      sec_fault_seen <= (sec_fault_seen & ~txn.start) | sec_bus.parity_fault;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h0;
      irq <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // active low pins, driven high one cycle after release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_parity_err_out <= 1'b1;
      primary_parity_err_oe <= 1'b0;
      secondary_parity_err_out <= 1'b1;
      secondary_parity_err_oe <= 1'b0;
    end
    else
    begin
      primary_parity_err_out <= ~pri_assert;
      primary_parity_err_oe <= pri_assert | ~primary_parity_err_out;
      secondary_parity_err_out <= ~sec_assert;
      secondary_parity_err_oe <= sec_assert | ~secondary_parity_err_out;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_pri_mdpd_set: assert property (
    pri_mdpd_cond && up |=> status[parity_report_pkg::PRI_MDPD_BIT]
  ) else $error("primary master parity bit not set");

  a_pri_mdpd_cause: assert property (
    $rose(status[parity_report_pkg::PRI_MDPD_BIT])
      |-> $past(up && pri_bus.bridge_master && pri_resp_en && pri_err)
  ) else $error("primary master parity bit set without upstream primary error");

  a_sec_mdpd_set: assert property (
    sec_mdpd_cond && !up |=> status[parity_report_pkg::SEC_MDPD_BIT]
  ) else $error("secondary master parity bit not set");

  a_sec_mdpd_cause: assert property (
    $rose(status[parity_report_pkg::SEC_MDPD_BIT])
      |-> $past(!up && sec_bus.bridge_master && sec_resp_en && sec_err)
  ) else $error("secondary master parity bit set without downstream secondary error");

  a_pri_pin_role: assert property (
    !primary_parity_err_out |-> $past(drives_pri || (sec_bus.completion && is_delayed))
  ) else $error("primary pin asserted outside its roles");

  a_pri_pin_enable: assert property (
    !primary_parity_err_out |-> $past(pri_resp_en)
  ) else $error("primary pin asserted with its enable clear");

  a_pri_pin_local: assert property (
    pri_resp_en && pri_local |=> !primary_parity_err_out ##1 primary_parity_err_oe
  ) else $error("primary pin missed a local error");

  a_pri_pin_fwd: assert property (
    pri_resp_en && pri_fwd |=> !primary_parity_err_out && primary_parity_err_oe
  ) else $error("secondary error not forwarded to primary pin");

  a_pri_fwd_block: assert property (
    !primary_parity_err_out |-> $past(pri_local || !pri_fault_seen)
  ) else $error("primary pin forwarded an error the primary side saw");

  a_sec_pin_role: assert property (
    !secondary_parity_err_out |-> $past(drives_sec || (pri_bus.completion && is_delayed))
  ) else $error("secondary pin asserted outside its roles");

  a_sec_pin_enable: assert property (
    !secondary_parity_err_out |-> $past(sec_resp_en)
  ) else $error("secondary pin asserted with its enable clear");

  a_sec_pin_assert: assert property (
    sec_resp_en && (sec_local || sec_fwd) |=> !secondary_parity_err_out
  ) else $error("secondary pin missed an error");

  a_status_held: assert property (
    status[parity_report_pkg::PRI_MDPD_BIT] && !(wr_status && reg_wdata[0])
      |=> status[parity_report_pkg::PRI_MDPD_BIT]
  ) else $error("primary master parity bit lost without a clear");

  a_pin_release: assert property (
    $rose(primary_parity_err_out) |-> primary_parity_err_oe
  ) else $error("primary pin not driven high after assertion");

  a_sec_pin_release: assert property (
    $rose(secondary_parity_err_out) |-> secondary_parity_err_oe
  ) else $error("secondary pin not driven high after assertion");

  a_sec_status_held: assert property (
    status[parity_report_pkg::SEC_MDPD_BIT]
      && !(wr_status && reg_wdata[parity_report_pkg::SEC_MDPD_BIT])
      |=> status[parity_report_pkg::SEC_MDPD_BIT]
  ) else $error("secondary master parity bit lost without a clear");

  a_status_clear: assert property (
    wr_status && reg_wdata[parity_report_pkg::PRI_MDPD_BIT] && !set_pri_mdpd
      |=> !status[parity_report_pkg::PRI_MDPD_BIT]
  ) else $error("primary master parity bit not cleared by a one");

  a_pri_mdpd_down: assert property (
    !up |=> !$rose(status[parity_report_pkg::PRI_MDPD_BIT])
  ) else $error("primary master parity bit set by a downstream transaction");

  a_sec_mdpd_up: assert property (
    up |=> !$rose(status[parity_report_pkg::SEC_MDPD_BIT])
  ) else $error("secondary master parity bit set by an upstream transaction");

  a_pri_oe_window: assert property (
    primary_parity_err_oe
      |-> !primary_parity_err_out || $past(!primary_parity_err_out)
  ) else $error("primary pin driven outside an assertion");

  a_sec_oe_window: assert property (
    secondary_parity_err_oe
      |-> !secondary_parity_err_out || $past(!secondary_parity_err_out)
  ) else $error("secondary pin driven outside an assertion");

  a_pri_upstream_write: assert property (
    up && is_write |=> primary_parity_err_out
  ) else $error("primary pin asserted on an upstream write");

  a_pri_downstream_read: assert property (
    !up && is_read |=> primary_parity_err_out
  ) else $error("primary pin asserted on a downstream read");

  a_sec_downstream_write: assert property (
    !up && is_write |=> secondary_parity_err_out
  ) else $error("secondary pin asserted on a downstream write");

  a_sec_upstream_read: assert property (
    up && is_read |=> secondary_parity_err_out
  ) else $error("secondary pin asserted on an upstream read");

  a_pri_fwd_quiet: assert property (
    pri_fault_seen && !pri_local |=> primary_parity_err_out
  ) else $error("primary pin forwarded after a primary fault in this transaction");

  a_sec_fwd_quiet: assert property (
    sec_fault_seen && !sec_local |=> secondary_parity_err_out
  ) else $error("secondary pin forwarded after a secondary fault in this transaction");

  a_sec_fwd_block: assert property (
    !secondary_parity_err_out |-> $past(sec_local || !sec_fault_seen)
  ) else $error("secondary pin forwarded an error the secondary side saw");

  a_sec_pin_fwd: assert property (
    sec_resp_en && sec_fwd |=> !secondary_parity_err_out && secondary_parity_err_oe
  ) else $error("primary error not forwarded to secondary pin");

  a_sec_pin_local: assert property (
    sec_resp_en && sec_local |=> !secondary_parity_err_out ##1 secondary_parity_err_oe
  ) else $error("secondary pin missed a local error");

endmodule : parity_report

`default_nettype wire

// ---- dv/bus_agents.sv ----
/*
  agents on the primary and secondary buses, each able to assert its parity
  error pin when the bench asks; the wire level is resolved here.
  assumes both pins carry pull-ups and the bridge drives through its enables.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_agents (
  input wire logic pri_out, // bridge primary drive value
  input wire logic pri_oe,  // bridge primary enable
  input wire logic pri_req, // agent asserts primary pin
  input wire logic sec_out, // bridge secondary drive value
  input wire logic sec_oe,  // bridge secondary enable
  input wire logic sec_req, // agent asserts secondary pin
  output logic pri_pin,     // resolved primary pin
  output logic sec_pin      // resolved secondary pin
);
  assign pri_pin = !((pri_oe && !pri_out) || pri_req);
  assign sec_pin = !((sec_oe && !sec_out) || sec_req);
endmodule : bus_agents

`default_nettype wire

// ---- dv/parity_report_test.sv ----
/*
  self-checking bench of the parity reporting block: a table of transaction
  cases under every enable setting, then sticky, blocked forward and register cases.
  assumes a 10 MHz clock and the bus agent model on both parity error pins.
*/
`timescale 1ns/1ps
`default_nettype none

module parity_report_test;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic irq;
  parity_report_pkg::txn_type txn = 4'h0;
  parity_report_pkg::bus_side_type pri_bus = 5'h00;
  parity_report_pkg::bus_side_type sec_bus = 5'h00;
  logic pri_req = 1'h0;
  logic sec_req = 1'h0;
  logic pri_pin, pri_out, pri_oe, sec_pin, sec_out, sec_oe;
  logic [31:0] got;
  logic [3:0] mask = 4'h0;
  int errors = 0;
  int num_checks = 0;
  // {sec pin, pri pin, sec status, pri status} by kind, direction, error bus
  logic [3:0] rows [12] = '{4'h0, 4'hA, 4'h5, 4'h0, 4'h4, 4'h2,
    4'h1, 4'h8, 4'h4, 4'h6, 4'h9, 4'h8};
  wire logic [31:0] pins = {28'h0, sec_out, sec_oe, pri_out, pri_oe};

  parity_report u_parity_report (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .txn(txn), .pri_bus(pri_bus),
    .sec_bus(sec_bus), .primary_parity_err_n(pri_pin), .primary_parity_err_out(pri_out),
    .primary_parity_err_oe(pri_oe), .secondary_parity_err_n(sec_pin),
    .secondary_parity_err_out(sec_out), .secondary_parity_err_oe(sec_oe)
  );

  bus_agents u_bus_agents (
    .pri_out(pri_out), .pri_oe(pri_oe), .pri_req(pri_req), .sec_out(sec_out),
    .sec_oe(sec_oe), .sec_req(sec_req), .pri_pin(pri_pin), .sec_pin(sec_pin)
  );

  always #50 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= addr;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    got = reg_rdata;
  endtask : reg_read

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // one transaction with a data parity error on one bus, then all effects
  task automatic run_row(input int idx, input logic [1:0] ctrl);
    logic up;
    logic err_sec;
    logic rcv_pri;
    logic dly;
    logic [3:0] e;
    parity_report_pkg::txn_kind_type kind;
    kind = parity_report_pkg::txn_kind_type'(idx / 4);
    up = idx[1];
    err_sec = idx[0];
    rcv_pri = (up == (kind == parity_report_pkg::KIND_READ));
    dly = (kind == parity_report_pkg::KIND_DELAYED);
    e = rows[idx] & {ctrl[1], ctrl[0], ctrl[1], ctrl[0]};
    if (ctrl != 2'h3)
      e = e & ((idx == 9) ? 4'hB : ((idx == 10) ? 4'h7 : 4'hF));
    @(posedge clk);
    txn <= {1'h1, kind, up};
    @(posedge clk);
    txn.start <= 1'h0;
    pri_bus <= {1'h1, up, !up, !err_sec && rcv_pri, dly};
    sec_bus <= {1'h1, !up, up, err_sec && !rcv_pri, dly};
    pri_req <= !err_sec && !rcv_pri;
    sec_req <= err_sec && rcv_pri;
    @(posedge clk);
    pri_bus <= 5'h00;
    sec_bus <= 5'h00;
    pri_req <= 1'h0;
    sec_req <= 1'h0;
    @(negedge clk);
    check("pins on", {28'h0, !e[3], e[3], !e[2], e[2]}, pins); // drive
    @(negedge clk);
    check("pins release", {28'h0, 1'h1, e[3], 1'h1, e[2]}, pins); // high drive
    @(negedge clk);
    check("pins idle", 32'hA, pins); // released
    check("irq", {31'h0, |(e & mask)}, {31'h0, irq});
    reg_read(parity_report_pkg::STATUS_OFFSET);
    check("status", {30'h0, e[1:0]}, got); // status bits
    reg_read(parity_report_pkg::IRQ_STATUS_OFFSET);
    check("irq status", {28'h0, e}, got);
    @(negedge clk);
    check("irq cleared", 32'h0, {31'h0, irq});
  endtask : run_row

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    check("pins after reset", 32'hA, pins); // idle high, undriven
    check("irq after reset", 32'h0, {31'h0, irq});
    for (int i = 0; i < 5; i++)
    begin
      reg_read(8'(i * 4));
      check("reset value", 32'h0, got);
    end
    reg_write(parity_report_pkg::CONTROL_OFFSET, 32'hFFFFFFFF);
    reg_write(8'h10, 32'hFFFFFFFF);
    reg_read(parity_report_pkg::CONTROL_OFFSET);
    check("control", 32'h3, got);
    reg_read(8'h10);
    check("unmapped", 32'h0, got);
    for (int c = 0; c < 4; c++)
    begin
      mask = (c == 3) ? 4'hF : 4'h3;
      reg_write(parity_report_pkg::IRQ_MASK_OFFSET, {28'h0, mask});
      reg_write(parity_report_pkg::CONTROL_OFFSET, 32'(c));
      for (int i = 0; i < 12; i++)
      begin
        run_row(i, 2'(c)); // every enable setting
        reg_write(parity_report_pkg::STATUS_OFFSET, 32'h3);
      end
    end
    run_row(2, 2'h3);
    reg_read(parity_report_pkg::STATUS_OFFSET);
    check("sticky", 32'h1, got); // held over reads
    reg_write(parity_report_pkg::STATUS_OFFSET, 32'h2);
    reg_read(parity_report_pkg::STATUS_OFFSET);
    check("zero write", 32'h1, got); // other bit kept
    reg_write(parity_report_pkg::STATUS_OFFSET, 32'h1);
    reg_read(parity_report_pkg::STATUS_OFFSET);
    check("one write", 32'h0, got); // cleared by one
    @(posedge clk);
    txn <= {1'h1, parity_report_pkg::KIND_DELAYED, 1'h0};
    @(posedge clk);
    txn.start <= 1'h0;
    // primary target with own parity fault
    pri_bus <= 5'h16;
    @(posedge clk);
    pri_bus <= 5'h00;
    repeat (3) @(posedge clk);
    // secondary master completion, agent reports error
    sec_bus <= 5'h19;
    sec_req <= 1'h1;
    @(posedge clk);
    sec_bus <= 5'h00;
    sec_req <= 1'h0;
    @(negedge clk);
    check("blocked forward", 32'hA, pins); // no forward
    // reset in mid-run with status, mask and interrupt set
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    check("pins after mid reset", 32'hA, pins); // idle high, undriven
    check("irq after mid reset", 32'h0, {31'h0, irq});
    reg_read(parity_report_pkg::STATUS_OFFSET);
    check("status after mid reset", 32'h0, got); // cleared by reset
    reg_read(parity_report_pkg::CONTROL_OFFSET);
    check("control after mid reset", 32'h0, got); // enables off
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule : parity_report_test

`default_nettype wire
